/* File: src/gpio_line_pkg.sv */
// Behaviour
// - four lines, index picks the target
// - direction makes line input or output
// - per-line polarity flip inverts logic sense
// - selected line level reads back
// - all levels in one word, bit n
// - per-line filters, kind pick, microsecond width
// - deglitch accepts change after width persists
// - debounce passes first edge, then blocks
// - deglitch feeds debounce
// - source pick drives output lines
// - trigger wait high while trigger accepted
// - exposure active high while sensor exposes
// - soft bit pick and level set one bit
// - soft bits word reads/writes all bits
// - read-only circuit type per line
// - aux rail switch only where supported
// - logic block output latched while enabled
package gpio_line_pkg;
  localparam int          NUM_LINES      = 4;
  localparam int          CLK_MHZ        = 25;
  localparam int          CYC_PER_US     = CLK_MHZ;
  localparam int          WIDTH_US_BITS  = 16;
  localparam int          CNT_BITS       = 21;
  // register byte offsets
  localparam logic [7:0]  ADDR_INDEX     = 8'h00;
  localparam logic [7:0]  ADDR_LINE_CTRL = 8'h04;
  localparam logic [7:0]  ADDR_FILTER    = 8'h08;
  localparam logic [7:0]  ADDR_LEVEL_ALL = 8'h0C;
  localparam logic [7:0]  ADDR_SOFT_PICK = 8'h10;
  localparam logic [7:0]  ADDR_SOFT_ALL  = 8'h14;
  // line control field positions
  localparam int          LC_DIR_BIT     = 0;
  localparam int          LC_FLIP_BIT    = 1;
  localparam int          LC_RAIL_BIT    = 2;
  localparam int          LC_LEVEL_BIT   = 3;
  localparam int          LC_SRC_LSB     = 4;
  localparam int          LC_SEL_LSB     = 8;
  localparam int          LC_TYPE_LSB    = 12;
  // filter register fields
  localparam int          FL_KIND_BIT    = 16;
  // soft pick register fields
  localparam int          SP_LEVEL_BIT   = 2;
  // reset values
  localparam logic [15:0] WIDTH_RST      = 16'h0000;
  localparam logic [3:0]  SOFT_RST       = 4'h0;
  // circuit type codes
  localparam logic [1:0]  TYPE_TRISTATE  = 2'h0;
  localparam logic [1:0]  TYPE_OPTO      = 2'h1;
  localparam logic [1:0]  TYPE_OPEN_DRAIN = 2'h2;
  localparam logic [3:0]  RAIL_CAPABLE   = 4'h4;

  typedef enum logic [2:0] {
    SRC_LINE      = 3'h0,
    SRC_SOFT_BIT  = 3'h1,
    SRC_COUNTER   = 3'h2,
    SRC_LOGIC     = 3'h3,
    SRC_EXPOSURE  = 3'h4,
    SRC_TRIG_WAIT = 3'h5
  } drive_src_e;
endpackage

/* File: src/line_filter.sv */
`timescale 1ns/1ns
module line_filter (
  input  wire logic                               clk_i,   // clock
  input  wire logic                               rst_i,   // sync reset
  input  wire logic                               raw_i,   // sampled level
  input  wire logic [gpio_line_pkg::CNT_BITS-1:0] glitch_i, // deglitch count
  input  wire logic [gpio_line_pkg::CNT_BITS-1:0] bounce_i, // debounce count
  output logic                                    out_o    // filtered level
);
  logic                               glitch_ff;
  logic [gpio_line_pkg::CNT_BITS-1:0] gcnt_ff;
  logic                               stage1;
  logic [gpio_line_pkg::CNT_BITS-1:0] bcnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      glitch_ff <= 1'b0;
      gcnt_ff   <= '0;
    end else if (raw_i == glitch_ff) begin
      gcnt_ff <= '0;
    end else if (gcnt_ff + 1'b1 >= glitch_i) begin
      glitch_ff <= raw_i;
      gcnt_ff   <= '0;
    end else begin
      gcnt_ff <= gcnt_ff + 1'b1;
    end
  end

  assign stage1 = (glitch_i == '0) ? raw_i : glitch_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o   <= 1'b0;
      bcnt_ff <= '0;
    end else if (bcnt_ff != '0) begin
      bcnt_ff <= bcnt_ff - 1'b1;
    end else if (stage1 != out_o) begin
      out_o   <= stage1;
      bcnt_ff <= bounce_i;
    end
  end
endmodule

/* File: src/camera_gpio_line_control.sv */
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module camera_gpio_line_control (
  input  wire logic        clk_i,          // 25 MHz clock
  input  wire logic        rst_i,          // sync reset, high
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // write enable
  input  wire logic [7:0]  wb_adr_i,       // byte address
  input  wire logic [3:0]  wb_sel_i,       // byte lanes
  input  wire logic [31:0] wb_dat_i,       // write data
  output logic [31:0]      wb_dat_o,       // read data
  output logic             wb_ack_o,       // acknowledge
  input  wire logic [3:0]  pin_i,          // pin levels
  output logic [3:0]       pin_o,          // pin drive levels
  output logic [3:0]       pin_oe_o,       // pin drive enables
  output logic [3:0]       aux_rail_o,     // aux rail switches
  input  wire logic [1:0]  counter_act_i,  // counter active
  input  wire logic [1:0]  logic_val_i,    // logic block value
  input  wire logic [1:0]  logic_en_i,     // logic block enable
  input  wire logic        exposing_i,     // sensor exposing
  input  wire logic        trig_ready_i    // frame trigger accepted
);
  localparam int N = gpio_line_pkg::NUM_LINES;
  localparam int CB = gpio_line_pkg::CNT_BITS;

  logic [1:0]   pin_index_pick_ff;
  logic [N-1:0] pin_direction_ff;
  logic [N-1:0] pin_polarity_flip_ff;
  logic [N-1:0] aux_rail_switch_ff;
  logic [2:0]   output_drive_pick_ff [N];
  logic [1:0]   drive_sel_ff [N];
  logic         filter_kind_pick_ff;
  logic [15:0]  glitch_us_ff [N];
  logic [15:0]  bounce_us_ff [N];
  logic [1:0]   soft_bit_pick_ff;
  logic [3:0]   soft_bits_word_ff;
  logic [1:0]   logic_latch_ff;
  logic [N-1:0] filt_level;
  logic [N-1:0] line_level;
  logic [N-1:0] drive_val;
  logic [1:0]   circuit_type [N];
  logic         wr;
  logic         rd;
  logic [31:0]  nxt_rdata;
  logic [1:0]   idx;

  assign idx = pin_index_pick_ff;
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // one wait cycle; ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_index_pick_ff <= 2'h0;
    end else if (wr && wb_adr_i == gpio_line_pkg::ADDR_INDEX
                 && wb_sel_i[0]) begin
      pin_index_pick_ff <= wb_dat_i[1:0];
    end
  end

  // per-line control fields, applied to the indexed line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_ff     <= '0;
      pin_polarity_flip_ff <= '0;
      aux_rail_switch_ff   <= '0;
      for (int i = 0; i < N; i++) begin
        output_drive_pick_ff[i] <= 3'h0;
        drive_sel_ff[i]         <= 2'h0;
      end
    end else if (wr && wb_adr_i == gpio_line_pkg::ADDR_LINE_CTRL) begin
      if (wb_sel_i[0]) begin
        pin_direction_ff[idx] <= wb_dat_i[gpio_line_pkg::LC_DIR_BIT];
        pin_polarity_flip_ff[idx] <= wb_dat_i[gpio_line_pkg::LC_FLIP_BIT];
        aux_rail_switch_ff[idx] <= wb_dat_i[gpio_line_pkg::LC_RAIL_BIT]
                                   & gpio_line_pkg::RAIL_CAPABLE[idx];
        output_drive_pick_ff[idx] <=
          wb_dat_i[gpio_line_pkg::LC_SRC_LSB +: 3];
      end
      if (wb_sel_i[1]) begin
        drive_sel_ff[idx] <= wb_dat_i[gpio_line_pkg::LC_SEL_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_kind_pick_ff <= 1'b0;
      for (int i = 0; i < N; i++) begin
        glitch_us_ff[i] <= gpio_line_pkg::WIDTH_RST;
        bounce_us_ff[i] <= gpio_line_pkg::WIDTH_RST;
      end
    end else if (wr && wb_adr_i == gpio_line_pkg::ADDR_FILTER) begin
      if (wb_sel_i[2]) begin
        filter_kind_pick_ff <= wb_dat_i[gpio_line_pkg::FL_KIND_BIT];
      end
      if (wb_sel_i[1:0] == 2'h3) begin
        if (wb_sel_i[2] ? wb_dat_i[gpio_line_pkg::FL_KIND_BIT]
                        : filter_kind_pick_ff) begin
          bounce_us_ff[idx] <= wb_dat_i[15:0];
        end else begin
          glitch_us_ff[idx] <= wb_dat_i[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_bit_pick_ff  <= 2'h0;
      soft_bits_word_ff <= gpio_line_pkg::SOFT_RST;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == gpio_line_pkg::ADDR_SOFT_PICK) begin
        soft_bit_pick_ff <= wb_dat_i[1:0];
        soft_bits_word_ff[wb_dat_i[1:0]] <=
          wb_dat_i[gpio_line_pkg::SP_LEVEL_BIT];
      end else if (wb_adr_i == gpio_line_pkg::ADDR_SOFT_ALL) begin
        soft_bits_word_ff <= wb_dat_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logic_latch_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (logic_en_i[i]) logic_latch_ff[i] <= logic_val_i[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      logic [CB-1:0] gcyc;
      logic [CB-1:0] bcyc;
      assign gcyc = CB'(glitch_us_ff[g] * gpio_line_pkg::CYC_PER_US);
      assign bcyc = CB'(bounce_us_ff[g] * gpio_line_pkg::CYC_PER_US);

      line_filter u_filt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .raw_i    (pin_i[g]),
        .glitch_i (gcyc),
        .bounce_i (bcyc),
        .out_o    (filt_level[g])
      );

      assign line_level[g] = pin_direction_ff[g]
                             ? drive_val[g]
                             : filt_level[g] ^ pin_polarity_flip_ff[g];

      always_comb begin
        unique case (output_drive_pick_ff[g])
          gpio_line_pkg::SRC_LINE:
            drive_val[g] = (drive_sel_ff[g] == 2'(g))
                           ? 1'b0
                           : filt_level[drive_sel_ff[g]]
                             ^ pin_polarity_flip_ff[drive_sel_ff[g]];
          gpio_line_pkg::SRC_SOFT_BIT:
            drive_val[g] = soft_bits_word_ff[drive_sel_ff[g]];
          gpio_line_pkg::SRC_COUNTER:
            drive_val[g] = counter_act_i[drive_sel_ff[g][0]];
          gpio_line_pkg::SRC_LOGIC:
            drive_val[g] = logic_latch_ff[drive_sel_ff[g][0]];
          gpio_line_pkg::SRC_EXPOSURE:
            drive_val[g] = exposing_i;
          gpio_line_pkg::SRC_TRIG_WAIT:
            drive_val[g] = trig_ready_i;
          default:
            drive_val[g] = 1'b0;
        endcase
      end

      assign circuit_type[g] = gpio_line_pkg::RAIL_CAPABLE[g]
                               ? gpio_line_pkg::TYPE_OPEN_DRAIN
                               : gpio_line_pkg::TYPE_TRISTATE;

      // open drain: drive low only when the value after the polarity flip is zero
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_o[g]      <= 1'b0;
          pin_oe_o[g]   <= 1'b0;
          aux_rail_o[g] <= 1'b0;
        end else begin
          pin_o[g]      <= 1'b0;
          pin_oe_o[g]   <= pin_direction_ff[g]
                           & ~(drive_val[g] ^ pin_polarity_flip_ff[g]);
          aux_rail_o[g] <= aux_rail_switch_ff[g];
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      gpio_line_pkg::ADDR_INDEX: nxt_rdata[1:0] = idx;
      gpio_line_pkg::ADDR_LINE_CTRL: begin
        nxt_rdata[gpio_line_pkg::LC_DIR_BIT]  = pin_direction_ff[idx];
        nxt_rdata[gpio_line_pkg::LC_FLIP_BIT] = pin_polarity_flip_ff[idx];
        nxt_rdata[gpio_line_pkg::LC_RAIL_BIT] = aux_rail_switch_ff[idx];
        nxt_rdata[gpio_line_pkg::LC_LEVEL_BIT] = line_level[idx];
        nxt_rdata[gpio_line_pkg::LC_SRC_LSB +: 3] =
          output_drive_pick_ff[idx];
        nxt_rdata[gpio_line_pkg::LC_SEL_LSB +: 2] = drive_sel_ff[idx];
        nxt_rdata[gpio_line_pkg::LC_TYPE_LSB +: 2] = circuit_type[idx];
      end
      gpio_line_pkg::ADDR_FILTER: begin
        nxt_rdata[gpio_line_pkg::FL_KIND_BIT] = filter_kind_pick_ff;
        nxt_rdata[15:0] = filter_kind_pick_ff ? bounce_us_ff[idx]
                                              : glitch_us_ff[idx];
      end
      gpio_line_pkg::ADDR_LEVEL_ALL: nxt_rdata[3:0] = line_level;
      gpio_line_pkg::ADDR_SOFT_PICK: begin
        nxt_rdata[1:0] = soft_bit_pick_ff;
        nxt_rdata[gpio_line_pkg::SP_LEVEL_BIT] =
          soft_bits_word_ff[soft_bit_pick_ff];
      end
      gpio_line_pkg::ADDR_SOFT_ALL: nxt_rdata[3:0] = soft_bits_word_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_dat_o <= 32'h0000_0000;
    else if (rd) wb_dat_o <= nxt_rdata;
  end
endmodule

/* File: dv/camera_gpio_line_control_assertions.sv */
`timescale 1ns/1ns
module gpio_line_checker (
  input wire logic        clk_i,         // clock
  input wire logic        rst_i,         // reset
  input wire logic        wb_cyc_i,      // cycle
  input wire logic        wb_stb_i,      // strobe
  input wire logic        wb_we_i,       // write
  input wire logic [7:0]  wb_adr_i,      // address
  input wire logic [3:0]  wb_sel_i,      // lanes
  input wire logic [31:0] wb_dat_i,      // wdata
  input wire logic [31:0] wb_dat_o,      // rdata
  input wire logic        wb_ack_o,      // ack
  input wire logic [3:0]  pin_i,         // pins
  input wire logic [3:0]  pin_o,         // drive
  input wire logic [3:0]  pin_oe_o,      // enables
  input wire logic [3:0]  aux_rail_o,    // rail
  input wire logic [1:0]  counter_act_i, // counter
  input wire logic [1:0]  logic_val_i,   // logic
  input wire logic [1:0]  logic_en_i,    // enable
  input wire logic        exposing_i,    // exposing
  input wire logic        trig_ready_i   // trigger
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_all;
    s_take ##0 (!wb_we_i && wb_adr_i == gpio_line_pkg::ADDR_LEVEL_ALL);
  endsequence
  sequence s_rd_hole;
    s_take ##0 (!wb_we_i && wb_adr_i > gpio_line_pkg::ADDR_SOFT_ALL);
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_caused: assert property (wb_ack_o |->
                                 $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_level_word: assert property (s_rd_all |=> wb_dat_o[31:4] == 28'h0)
    else $error("level word has stray bits");
  a_hole_zero: assert property (s_rd_hole |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_drive_low: assert property (pin_o == 4'h0)
    else $error("pin driven high");
  a_rail_capable: assert property ((aux_rail_o & 4'hB) == 4'h0)
    else $error("rail on unsupported line");
endmodule

bind camera_gpio_line_control gpio_line_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .aux_rail_o(aux_rail_o),
  .counter_act_i(counter_act_i), .logic_val_i(logic_val_i),
  .logic_en_i(logic_en_i), .exposing_i(exposing_i),
  .trig_ready_i(trig_ready_i));

/* File: dv/gpio_pin_world.sv */
`timescale 1ns/1ns
module gpio_pin_world (
  input  wire logic [3:0] ext_i, // switch levels
  input  wire logic [3:0] oe_i,  // device pulls low
  output logic      [3:0] pin_o  // wire level
);
  assign pin_o = ext_i & ~oe_i;
endmodule

/* File: dv/camera_gpio_line_control_test.sv */
`timescale 1ns/1ns
module camera_gpio_line_control_test;
  localparam logic [7:0] IX = gpio_line_pkg::ADDR_INDEX;
  localparam logic [7:0] LC = gpio_line_pkg::ADDR_LINE_CTRL;
  localparam logic [7:0] FL = gpio_line_pkg::ADDR_FILTER;
  localparam logic [7:0] LA = gpio_line_pkg::ADDR_LEVEL_ALL;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic        ack;
  logic [3:0]  pin, po, oe, rail;
  logic [3:0]  ext = 4'hA;
  logic [3:0]  sel = 4'hF;
  logic [1:0]  cnt = 2'h0, lval = 2'h0, len = 2'h3;
  logic        expo = 1'b0, trig = 1'b0;
  int          fail_count = 0;
  int          cmp_count = 0;
  always #20 clk_i = ~clk_i;
  gpio_pin_world world (.ext_i(ext), .oe_i(oe), .pin_o(pin));
  camera_gpio_line_control dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(pin), .pin_o(po), .pin_oe_o(oe), .aux_rail_o(rail),
    .counter_act_i(cnt), .logic_val_i(lval), .logic_en_i(len),
    .exposing_i(expo), .trig_ready_i(trig));
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        fail_count++;
        $display("MISMATCH %0t bus answer timed out", $time);
        conclude();
      end
    end while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic lvl(input logic e);
    bus(1'b0, LC, 32'h0);
    check(got[3], e);
  endtask
  initial begin
    logic [1:0] ty;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    for (int i = 0; i < 4; i++) begin
      ty = (i == 2) ? gpio_line_pkg::TYPE_OPEN_DRAIN
                    : gpio_line_pkg::TYPE_TRISTATE;
      bus(1'b1, IX, i);
      bus(1'b0, LC, 32'h0);
      check({got[13:12], got[2:0]}, {ty, 3'h0});
    end
    bus(1'b0, LA, 32'h0);
    check(got, 32'hA);
    lvl(1'b1);
    bus(1'b1, LC, 32'h2);
    tick(4);
    lvl(1'b0);
    bus(1'b0, LA, 32'h0);
    check(got, 32'h2);
    bus(1'b1, LC, 32'h0);
    bus(1'b1, IX, 32'h2);
    bus(1'b1, LC, 32'h11);
    bus(1'b1, gpio_line_pkg::ADDR_SOFT_ALL, 32'h1);
    tick(4);
    check(oe[2], 1'b0);
    lvl(1'b1);
    bus(1'b1, gpio_line_pkg::ADDR_SOFT_PICK, 32'h0);
    tick(4);
    check(oe[2], 1'b1);
    check(po, 4'h0);
    bus(1'b1, gpio_line_pkg::ADDR_SOFT_PICK, 32'h6);
    bus(1'b0, gpio_line_pkg::ADDR_SOFT_ALL, 32'h0);
    check(got, 32'h4);
    bus(1'b1, LC, 32'h13);
    tick(4);
    check(oe[2], 1'b0);
    for (int s = 2; s < 6; s++) begin
      bus(1'b1, LC, 32'h1 | (s << 4));
      for (int v = 1; v >= 0; v--) begin
        cnt <= {2{(s == 2) ~^ v[0]}};
        lval <= {2{(s == 3) ~^ v[0]}};
        expo <= (s == 4) ~^ v[0];
        trig <= (s == 5) ~^ v[0];
        tick(4);
        check(oe[2], !v[0]);
      end
    end
    bus(1'b1, LC, 32'h31);
    lval <= 2'h3;
    tick(4);
    len <= 2'h0;
    lval <= 2'h0;
    tick(4);
    check(oe[2], 1'b0);
    len <= 2'h3;
    tick(4);
    check(oe[2], 1'b1);
    bus(1'b1, LC, 32'h30);
    tick(4);
    check(oe[2], 1'b0);
    bus(1'b1, LC, 32'h101);
    tick(4);
    check(oe[2], 1'b0);
    ext[1] <= 1'b0;
    tick(4);
    check(oe[2], 1'b1);
    bus(1'b1, LC, 32'h4);
    tick(2);
    check(rail, 4'h4);
    bus(1'b1, IX, 32'h0);
    bus(1'b1, LC, 32'h4);
    tick(2);
    check(rail, 4'h4);
    bus(1'b1, FL, 32'h2);
    ext[0] <= 1'b1;
    tick(10);
    ext[0] <= 1'b0;
    tick(80);
    lvl(1'b0);
    ext[0] <= 1'b1;
    tick(38);
    lvl(1'b0);
    tick(30);
    lvl(1'b1);
    bus(1'b1, IX, 32'h3);
    bus(1'b1, FL, 32'h10002);
    ext[3] <= 1'b0;
    tick(4);
    lvl(1'b0);
    ext[3] <= 1'b1;
    tick(10);
    lvl(1'b0);
    tick(60);
    lvl(1'b1);
    // kind only, then width under the stored kind
    sel <= 4'h4;
    bus(1'b1, FL, 32'h0);
    sel <= 4'h3;
    bus(1'b1, FL, 32'h1);
    sel <= 4'hF;
    bus(1'b0, FL, 32'h0);
    check(got, 32'h1);
    sel <= 4'h4;
    bus(1'b1, FL, 32'h10000);
    sel <= 4'hF;
    bus(1'b0, FL, 32'h0);
    check(got, 32'h10002);
    // short dip must die in deglitch before debounce sees it
    tick(60);
    ext[3] <= 1'b0;
    tick(5);
    lvl(1'b1);
    ext[3] <= 1'b1;
    tick(60);
    lvl(1'b1);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    check(got, 32'h0);
    conclude();
  end
endmodule
